// ==== common/tpsi2c_pkg.sv ====
// constants and types shared by the serial bus slave
package tpsi2c_pkg;
	// =====================================================
	// bus address
	localparam logic [7:0] OWN_ADDR_WRITE = 8'h6c;
	localparam logic [6:0] OWN_ADDR7 = OWN_ADDR_WRITE[7:1];
	// =====================================================
	// byte handling
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [7:0] IDLE_TX_BYTE = 8'hff;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// =====================================================
	// core to link crossing vector
	localparam int C2L_RST = 0;
	localparam int C2L_EN = 1;
	localparam int C2L_TXP = 2;
	localparam int C2L_W = 3;
	// =====================================================
	// link to core crossing vector
	localparam int L2C_RX = 0;
	localparam int L2C_AM = 1;
	localparam int L2C_RD = 2;
	localparam int L2C_STOP = 3;
	localparam int L2C_TAKEN = 4;
	localparam int L2C_SDA = 5;
	localparam int L2C_EVW = 5;
	localparam int L2C_W = 6;
	// =====================================================
	// link engine states
	typedef enum logic [2:0] {
		LS_IDLE,
		LS_ADDR,
		LS_ADDR_ACK,
		LS_RX,
		LS_RX_ACK,
		LS_TX,
		LS_TX_ACK,
		LS_IGNORE
	} tpsi2c_lstate_e;
endpackage

// ==== common/tpsi2c_sync_if.sv ====
// two-flop crossing carrier between the slave and its synchroniser
`timescale 1ns/1ps
interface tpsi2c_sync_if #(
	parameter int W = 1
);
	logic [W-1:0] d;
	logic [W-1:0] q;
	modport src (
		output d,
		input q
	);
	modport dst (
		input d,
		output q
	);
endinterface

// ==== verilog/tpsi2c_sync.sv ====
// two-flop level synchroniser into the clock it is given
`timescale 1ns/1ps
module tpsi2c_sync #(
	parameter int W = 1
) (
	// destination clock
	input wire logic i_clock,
	// crossing
	tpsi2c_sync_if.dst bus
);
	// =====================================================
	// state
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} tpsi2c_sync_s;

	tpsi2c_sync_s sy_r;
	tpsi2c_sync_s sy_nxt;

	// no reset: pure pass of levels, settles within two edges
	always_comb begin
		sy_nxt = sy_r;
		sy_nxt.s1 = bus.d;
		sy_nxt.s2 = sy_r.s1;
	end

	always_ff @(posedge i_clock) begin
		sy_r <= sy_nxt;
	end

	assign bus.q = sy_r.s2;
endmodule

// ==== verilog/tpsi2c_slave.sv ====
// fixed-address serial bus slave with receive and transmit data paths
`timescale 1ns/1ps
module tpsi2c_slave (
	// core clock and reset
	input wire logic i_clock,
	input wire logic i_srst,
	// link sampling clock
	input wire logic i_link_clock,
	// control
	input wire logic i_serial_bus_enable,
	input wire logic i_power_down,
	input wire logic i_pin0_pullup_in_ctrl,
	input wire logic i_pin0_pullup_out_ctrl,
	input wire logic i_pin1_pullup_in_ctrl,
	input wire logic i_pin1_pullup_out_ctrl,
	// software port setup used while disabled
	input wire logic [1:0] i_sw_pin_out,
	input wire logic [1:0] i_sw_pin_oe,
	// data register access
	input wire logic i_data_read,
	input wire logic i_data_write,
	input wire logic [7:0] i_tx_data,
	input wire logic i_status_clear,
	// pins
	input wire logic i_port_pin_zero,
	input wire logic i_port_pin_one,
	output logic o_port_pin_zero_out,
	output logic o_port_pin_zero_oe,
	output logic o_port_pin_one_out,
	output logic o_port_pin_one_oe,
	output logic o_pin0_pullup_en,
	output logic o_pin1_pullup_en,
	// status and data
	output logic [7:0] o_bus_data_reg,
	output logic o_addr_match_flag,
	output logic o_rx_buffer_full_flag,
	output logic o_stop_flag,
	output logic o_read_request_flag,
	output logic o_tx_buffer_full_flag,
	output logic o_overflow_flag
);
	// =====================================================
	// crossings
	tpsi2c_sync_if #(.W(tpsi2c_pkg::C2L_W)) c2l ();
	tpsi2c_sync_if #(.W(tpsi2c_pkg::L2C_W)) l2c ();

	tpsi2c_sync #(.W(tpsi2c_pkg::C2L_W)) u_c2l (
		.i_clock(i_link_clock),
		.bus(c2l)
	);

	tpsi2c_sync #(.W(tpsi2c_pkg::L2C_W)) u_l2c (
		.i_clock(i_clock),
		.bus(l2c)
	);

	// =====================================================
	// link domain state
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_d;
		logic sda_d;
		tpsi2c_pkg::tpsi2c_lstate_e st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] tsh;
		logic [7:0] rx_data;
		logic mack;
		logic active;
		logic sda_oe;
		logic rx_t;
		logic am_t;
		logic rd_t;
		logic stop_t;
		logic taken_t;
	} tpsi2c_link_s;

	// =====================================================
	// core domain state
	typedef struct packed {
		logic [7:0] rx_data;
		logic [7:0] tx_data;
		logic rbf;
		logic tbf;
		logic am;
		logic stp;
		logic rd;
		logic ovf;
		logic en;
		logic tx_pend;
		logic [tpsi2c_pkg::L2C_EVW-1:0] seen;
		logic p0_out;
		logic p0_oe;
		logic p1_out;
		logic p1_oe;
		logic pu0;
		logic pu1;
	} tpsi2c_core_s;

	tpsi2c_link_s l_r;
	tpsi2c_link_s l_nxt;
	tpsi2c_core_s c_r;
	tpsi2c_core_s c_nxt;

	// =====================================================
	// helpers
	function automatic logic [7:0] tx_pick(input logic pend, input logic taken,
			input logic [7:0] d);
		// nothing pending: send all ones, which the master sees as idle bus
		tx_pick = (pend != taken) ? d : tpsi2c_pkg::IDLE_TX_BYTE;
	endfunction

	logic l_rst;
	logic l_en;
	logic l_pend;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	assign l_rst = c2l.q[tpsi2c_pkg::C2L_RST];
	assign l_en = c2l.q[tpsi2c_pkg::C2L_EN];
	assign l_pend = c2l.q[tpsi2c_pkg::C2L_TXP];
	assign scl = l_r.scl_s[1];
	assign sda = l_r.sda_s[1];
	assign scl_rise = scl & ~l_r.scl_d;
	assign scl_fall = ~scl & l_r.scl_d;
	assign bus_start = scl & l_r.scl_d & ~sda & l_r.sda_d;
	assign bus_stop = scl & l_r.scl_d & sda & ~l_r.sda_d;

	// =====================================================
	// link engine
	always_comb begin
		l_nxt = l_r;
		l_nxt.scl_s = {l_r.scl_s[0], i_port_pin_zero};
		l_nxt.sda_s = {l_r.sda_s[0], i_port_pin_one};
		l_nxt.scl_d = scl;
		l_nxt.sda_d = sda;
		if (!l_en) begin
			l_nxt.st = tpsi2c_pkg::LS_IDLE;
			l_nxt.sda_oe = 1'b0;
			l_nxt.active = 1'b0;
		end else if (bus_start) begin
			l_nxt.st = tpsi2c_pkg::LS_ADDR;
			l_nxt.cnt = tpsi2c_pkg::CNT_ZERO;
			l_nxt.sda_oe = 1'b0;
			l_nxt.active = 1'b0;
		end else if (bus_stop) begin
			if (l_r.active) begin
				l_nxt.stop_t = ~l_r.stop_t;
			end
			l_nxt.st = tpsi2c_pkg::LS_IDLE;
			l_nxt.sda_oe = 1'b0;
			l_nxt.active = 1'b0;
		end else begin
			case (l_r.st)
				tpsi2c_pkg::LS_ADDR: begin
					if (scl_rise) begin
						l_nxt.sh = {l_r.sh[6:0], sda};
						l_nxt.cnt = l_r.cnt + tpsi2c_pkg::CNT_ONE;
					end else if (scl_fall && l_r.cnt == tpsi2c_pkg::BYTE_BITS) begin
						if (l_r.sh[7:1] == tpsi2c_pkg::OWN_ADDR7) begin
							l_nxt.sda_oe = 1'b1;
							l_nxt.am_t = ~l_r.am_t;
							l_nxt.active = 1'b1;
							l_nxt.mack = l_r.sh[0];
							if (l_r.sh[0]) begin
								l_nxt.rd_t = ~l_r.rd_t;
							end
							l_nxt.st = tpsi2c_pkg::LS_ADDR_ACK;
						end else begin
							l_nxt.st = tpsi2c_pkg::LS_IGNORE;
						end
					end
				end
				tpsi2c_pkg::LS_ADDR_ACK: begin
					if (scl_fall) begin
						l_nxt.cnt = tpsi2c_pkg::CNT_ZERO;
						if (l_r.mack) begin
							l_nxt.tsh = tx_pick(l_pend, l_r.taken_t, c_r.tx_data);
							l_nxt.taken_t = l_pend;
							l_nxt.sda_oe = ~tx_pick(l_pend, l_r.taken_t, c_r.tx_data) >> 7 == 8'h01;
							l_nxt.st = tpsi2c_pkg::LS_TX;
						end else begin
							l_nxt.sda_oe = 1'b0;
							l_nxt.st = tpsi2c_pkg::LS_RX;
						end
					end
				end
				tpsi2c_pkg::LS_RX: begin
					if (scl_rise) begin
						l_nxt.sh = {l_r.sh[6:0], sda};
						l_nxt.cnt = l_r.cnt + tpsi2c_pkg::CNT_ONE;
					end else if (scl_fall && l_r.cnt == tpsi2c_pkg::BYTE_BITS) begin
						l_nxt.rx_data = l_r.sh;
						l_nxt.rx_t = ~l_r.rx_t;
						l_nxt.sda_oe = 1'b1;
						l_nxt.st = tpsi2c_pkg::LS_RX_ACK;
					end
				end
				tpsi2c_pkg::LS_RX_ACK: begin
					if (scl_fall) begin
						l_nxt.sda_oe = 1'b0;
						l_nxt.cnt = tpsi2c_pkg::CNT_ZERO;
						l_nxt.st = tpsi2c_pkg::LS_RX;
					end
				end
				tpsi2c_pkg::LS_TX: begin
					if (scl_rise) begin
						l_nxt.cnt = l_r.cnt + tpsi2c_pkg::CNT_ONE;
					end else if (scl_fall) begin
						if (l_r.cnt == tpsi2c_pkg::BYTE_BITS) begin
							l_nxt.sda_oe = 1'b0;
							l_nxt.st = tpsi2c_pkg::LS_TX_ACK;
						end else begin
							l_nxt.tsh = {l_r.tsh[6:0], 1'b0};
							l_nxt.sda_oe = ~l_r.tsh[6];
						end
					end
				end
				tpsi2c_pkg::LS_TX_ACK: begin
					if (scl_rise) begin
						l_nxt.mack = ~sda;
					end else if (scl_fall) begin
						l_nxt.cnt = tpsi2c_pkg::CNT_ZERO;
						if (l_r.mack) begin
							l_nxt.tsh = tx_pick(l_pend, l_r.taken_t, c_r.tx_data);
							l_nxt.taken_t = l_pend;
							l_nxt.sda_oe = ~tx_pick(l_pend, l_r.taken_t, c_r.tx_data) >> 7 == 8'h01;
							l_nxt.st = tpsi2c_pkg::LS_TX;
						end else begin
							l_nxt.st = tpsi2c_pkg::LS_IGNORE;
						end
					end
				end
				default: begin
					l_nxt.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_link_clock) begin
		if (l_rst) begin
			l_r <= '0;
			l_r.st <= tpsi2c_pkg::LS_IDLE;
			l_r.scl_s <= l_nxt.scl_s;
			l_r.sda_s <= l_nxt.sda_s;
		end else begin
			l_r <= l_nxt;
		end
	end

	assign l2c.d = {l_r.sda_oe, l_r.taken_t, l_r.stop_t, l_r.rd_t, l_r.am_t, l_r.rx_t};

	// =====================================================
	// core registers and flags
	logic [tpsi2c_pkg::L2C_EVW-1:0] ev;
	logic en_now;
	logic tbf_eff;

	assign ev = l2c.q[tpsi2c_pkg::L2C_EVW-1:0] ^ c_r.seen;
	assign en_now = i_serial_bus_enable & ~i_power_down;
	assign tbf_eff = c_r.tbf & ~ev[tpsi2c_pkg::L2C_TAKEN];

	always_comb begin
		c_nxt = c_r;
		c_nxt.seen = l2c.q[tpsi2c_pkg::L2C_EVW-1:0];
		c_nxt.en = en_now;
		// clears first so that a same-cycle event wins
		if (i_status_clear) begin
			c_nxt.am = 1'b0;
			c_nxt.stp = 1'b0;
			c_nxt.rd = 1'b0;
			c_nxt.ovf = 1'b0;
		end
		if (i_data_read) begin
			c_nxt.rbf = 1'b0;
		end
		if (ev[tpsi2c_pkg::L2C_RX]) begin
			c_nxt.rx_data = c_r.rx_data;
			c_nxt.rx_data = l_r.rx_data;
			if (c_r.rbf && !i_data_read) begin
				c_nxt.ovf = 1'b1;
			end
			c_nxt.rbf = 1'b1;
		end
		if (ev[tpsi2c_pkg::L2C_AM]) begin
			c_nxt.am = 1'b1;
			c_nxt.rd = 1'b0;
		end
		if (ev[tpsi2c_pkg::L2C_RD]) begin
			c_nxt.rd = 1'b1;
		end
		if (ev[tpsi2c_pkg::L2C_STOP]) begin
			c_nxt.stp = 1'b1;
			c_nxt.rd = 1'b0;
		end
		if (ev[tpsi2c_pkg::L2C_TAKEN]) begin
			c_nxt.tbf = 1'b0;
		end
		if (i_data_write) begin
			// an early write is dropped so the crossing data never moves under the link
			if (tbf_eff) begin
				c_nxt.ovf = 1'b1;
			end else begin
				c_nxt.tx_data = i_tx_data;
				c_nxt.tbf = 1'b1;
				c_nxt.tx_pend = ~c_r.tx_pend;
			end
		end
		if (c_r.en) begin
			c_nxt.p0_out = 1'b0;
			c_nxt.p0_oe = 1'b0;
			c_nxt.p1_out = 1'b0;
			c_nxt.p1_oe = l2c.q[tpsi2c_pkg::L2C_SDA];
		end else begin
			c_nxt.p0_out = i_sw_pin_out[0];
			c_nxt.p0_oe = i_sw_pin_oe[0];
			c_nxt.p1_out = i_sw_pin_out[1];
			c_nxt.p1_oe = i_sw_pin_oe[1];
		end
		c_nxt.pu0 = i_pin0_pullup_in_ctrl & i_pin0_pullup_out_ctrl;
		c_nxt.pu1 = i_pin1_pullup_in_ctrl & i_pin1_pullup_out_ctrl;
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			c_r <= '0;
			c_r.rx_data <= tpsi2c_pkg::DATA_RESET;
			c_r.tx_data <= tpsi2c_pkg::DATA_RESET;
		end else begin
			c_r <= c_nxt;
		end
	end

	assign c2l.d = {c_r.tx_pend, c_r.en, i_srst};

	// =====================================================
	// outputs
	assign o_port_pin_zero_out = c_r.p0_out;
	assign o_port_pin_zero_oe = c_r.p0_oe;
	assign o_port_pin_one_out = c_r.p1_out;
	assign o_port_pin_one_oe = c_r.p1_oe;
	assign o_pin0_pullup_en = c_r.pu0;
	assign o_pin1_pullup_en = c_r.pu1;
	assign o_bus_data_reg = c_r.rx_data;
	assign o_addr_match_flag = c_r.am;
	assign o_rx_buffer_full_flag = c_r.rbf;
	assign o_stop_flag = c_r.stp;
	assign o_read_request_flag = c_r.rd;
	assign o_tx_buffer_full_flag = c_r.tbf;
	assign o_overflow_flag = c_r.ovf;
endmodule

// ==== verif/tpsi2c_monitor.sv ====
// port checks for the serial bus slave
`timescale 1ns/1ps
module tpsi2c_monitor (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_srst,
	// control
	input wire logic i_serial_bus_enable,
	input wire logic i_power_down,
	input wire logic i_pin0_pullup_in_ctrl,
	input wire logic i_pin0_pullup_out_ctrl,
	input wire logic [1:0] i_sw_pin_out,
	input wire logic [1:0] i_sw_pin_oe,
	input wire logic i_data_read,
	input wire logic i_data_write,
	input wire logic i_status_clear,
	// outputs
	input wire logic o_port_pin_zero_out,
	input wire logic o_port_pin_zero_oe,
	input wire logic o_port_pin_one_out,
	input wire logic o_port_pin_one_oe,
	input wire logic o_pin0_pullup_en,
	input wire logic o_rx_buffer_full_flag,
	input wire logic o_stop_flag,
	input wire logic o_tx_buffer_full_flag,
	input wire logic o_overflow_flag
);
	// ====
	// history; enable crosses to the link first, so allow slack
	logic [1:0] up_r;
	logic [7:0] en_r;
	always_ff @(posedge i_clock) begin
		up_r <= {up_r[0], !i_srst};
		en_r <= {en_r[6:0], i_serial_bus_enable && !i_power_down && !i_srst};
	end
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (i_srst);
	// ====
	// checks
	a_pullup_pair: assert property (&up_r |->
		o_pin0_pullup_en == $past(i_pin0_pullup_in_ctrl && i_pin0_pullup_out_ctrl))
		else $error("bad pull-up enable");
	a_sda_low_only: assert property (
		&en_r && o_port_pin_one_oe |-> !o_port_pin_one_out)
		else $error("data driven high");
	a_clock_input: assert property (&en_r |-> !o_port_pin_zero_oe)
		else $error("clock pin driven");
	// the enable copy lags one edge, so power-down must have stood two edges
	a_pins_kept: assert property (&up_r && $past(i_power_down) && $past(i_power_down, 2) |->
		{o_port_pin_one_oe, o_port_pin_zero_oe, o_port_pin_one_out, o_port_pin_zero_out}
		== $past({i_sw_pin_oe, i_sw_pin_out}))
		else $error("pins not software setup");
	a_read_clears: assert property (i_data_read |=> !o_rx_buffer_full_flag)
		else $error("rx full kept");
	a_tx_pending: assert property (
		i_data_write && !o_tx_buffer_full_flag |=> o_tx_buffer_full_flag)
		else $error("tx full missing");
	a_early_write: assert property (
		i_data_write && o_tx_buffer_full_flag |=> o_overflow_flag)
		else $error("overflow missing");
	a_stop_clear: assert property (i_status_clear |=> !o_stop_flag)
		else $error("stop kept");
	c_overflow: cover property (o_overflow_flag);
	c_stop: cover property (o_stop_flag);
	c_tx_full: cover property (o_tx_buffer_full_flag);
endmodule
bind tpsi2c_slave tpsi2c_monitor mon (.*);

// ==== verif/tpsi2c_master.sv ====
// open-drain bus master model
`timescale 1ns/1ps
module tpsi2c_master (
	// bus
	input wire logic i_sda,
	// pulls
	output logic o_scl_low,
	output logic o_sda_low
);
	// ====
	// low phase kept above one microsecond
	localparam time T = 1500;
	initial begin
		o_scl_low = 1'b0;
		o_sda_low = 1'b0;
	end
	// lines are only pulled low or released
	task automatic bus_start();
		o_sda_low = 1'b0;
		#T o_scl_low = 1'b0;
		#T o_sda_low = 1'b1;
		#T o_scl_low = 1'b1;
		#T;
	endtask
	task automatic bus_stop();
		o_sda_low = 1'b1;
		#T o_scl_low = 1'b0;
		#T o_sda_low = 1'b0;
		#T;
	endtask
	// msb first; bit 0 is the acknowledge slot
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			o_sda_low = !d[i];
			#T o_scl_low = 1'b0;
			#T q[i] = i_sda;
			o_scl_low = 1'b1;
			#T;
		end
	endtask
endmodule

// ==== verif/tpsi2c_slave_bench.sv ====
// self-checking bench for the serial bus slave
`timescale 1ns/1ps
module tpsi2c_slave_bench;
	logic i_clock = 1'b0;
	logic lclk = 1'b0;
	logic i_srst = 1'b1;
	logic en = 1'b0;
	logic pd = 1'b0;
	logic [3:0] pu = 4'h0;
	logic [1:0] sw_out = 2'h0;
	logic [1:0] sw_oe = 2'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic clr = 1'b0;
	logic [7:0] txd = 8'h00;
	logic scl_low, sda_low, scl, sda, z_out, z_oe, d_out, d_oe;
	logic am, rbf, stp, rrq, tbf, ovf;
	logic [1:0] pull;
	logic [7:0] data, b;
	logic [8:0] q;
	logic [7:0] mq[$];
	int error_cnt = 0;
	int comparisons = 0;
	// pull-ups keep released lines high
	assign scl = !(scl_low || (z_oe && !z_out));
	assign sda = !(sda_low || (d_oe && !d_out));
	tpsi2c_slave uut (
		.i_clock(i_clock), .i_srst(i_srst), .i_link_clock(lclk),
		.i_serial_bus_enable(en), .i_power_down(pd),
		.i_pin0_pullup_in_ctrl(pu[0]), .i_pin0_pullup_out_ctrl(pu[1]),
		.i_pin1_pullup_in_ctrl(pu[2]), .i_pin1_pullup_out_ctrl(pu[3]),
		.i_sw_pin_out(sw_out), .i_sw_pin_oe(sw_oe), .i_data_read(rd),
		.i_data_write(wr), .i_tx_data(txd), .i_status_clear(clr),
		.i_port_pin_zero(scl), .i_port_pin_one(sda),
		.o_port_pin_zero_out(z_out), .o_port_pin_zero_oe(z_oe),
		.o_port_pin_one_out(d_out), .o_port_pin_one_oe(d_oe),
		.o_pin0_pullup_en(pull[0]), .o_pin1_pullup_en(pull[1]),
		.o_bus_data_reg(data), .o_addr_match_flag(am), .o_rx_buffer_full_flag(rbf),
		.o_stop_flag(stp), .o_read_request_flag(rrq),
		.o_tx_buffer_full_flag(tbf), .o_overflow_flag(ovf)
	);
	tpsi2c_master m (.i_sda(sda), .o_scl_low(scl_low), .o_sda_low(sda_low));
	initial begin
		forever #12.5 i_clock = !i_clock;
	end
	initial begin
		#7;
		forever #32 lclk = !lclk;
	end
	// ====
	// helpers
	task automatic close_out();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// arguments are copied at the call, so callers settle on a falling edge first
	task automatic chk(input string n, input logic [8:0] g, input logic [8:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// let n rising edges pass, then stop on a falling edge where outputs are settled
	task automatic settle(input int n);
		repeat (n) @(posedge i_clock);
		@(negedge i_clock);
	endtask
	// one-cycle pulse: 0 read, 1 write, 2 clear
	task automatic pulse(input int k, input logic [7:0] d);
		@(posedge i_clock);
		rd <= k == 0;
		wr <= k == 1;
		clr <= k == 2;
		txd <= d;
		@(posedge i_clock);
		rd <= 1'b0;
		wr <= 1'b0;
		clr <= 1'b0;
		repeat (2) @(posedge i_clock);
	endtask
	initial begin
		#2ms;
		error_cnt++;
		close_out();
	end
	// ====
	// sequence
	initial begin
		void'($urandom(32'h169303dc));
		repeat (16) @(posedge i_clock);
		i_srst <= 1'b0;
		en <= 1'b1;
		pd <= 1'b1;
		sw_oe <= 2'($urandom);
		sw_out <= 2'($urandom);
		settle(4);
		chk("pins", {d_oe, z_oe, d_out, z_out}, {sw_oe, sw_out});
		@(posedge i_clock);
		en <= 1'b0;
		pd <= 1'b0;
		// software setup released so the lines float high for the master
		sw_oe <= 2'h0;
		settle(12);
		m.bus_start();
		m.xfer({8'h6c, 1'b1}, q);
		settle(0);
		chk("ack_off", q[0], 1'b1);
		m.bus_stop();
		for (int i = 0; i < 16; i++) begin
			@(posedge i_clock);
			pu <= 4'(i);
			settle(2);
			chk("pullup", pull, {&pu[3:2], &pu[1:0]});
		end
		@(posedge i_clock);
		en <= 1'b1;
		settle(10);
		chk("scl_oe", z_oe, 1'b0);
		// foreign address: no ack, frame ignored
		m.bus_start();
		m.xfer({7'h36 ^ 7'($urandom_range(1, 127)), 1'($urandom), 1'b1}, q);
		settle(0);
		chk("ack_foreign", q[0], 1'b1);
		m.xfer({8'($urandom), 1'b1}, q);
		settle(0);
		chk("ack_ignored", q[0], 1'b1);
		m.bus_stop();
		settle(0);
		chk("foreign_flags", {am, rbf, stp}, 3'h0);
		// write; last two bytes left unread
		m.bus_start();
		m.xfer({8'h6c, 1'b1}, q);
		settle(0);
		chk("ack_addr", q[0], 1'b0);
		chk("am", am, 1'b1);
		for (int i = 0; i < 5; i++) begin
			b = 8'($urandom);
			mq.push_back(b);
			m.xfer({b, 1'b1}, q);
			settle(0);
			chk("ack_data", q[0], 1'b0);
			chk("rbf", rbf, 1'b1);
			chk("data", data, mq.pop_front());
			if (i < 3) begin
				pulse(0, 8'h00);
				settle(0);
				chk("rbf_read", rbf, 1'b0);
			end
		end
		chk("ovf_rx", ovf, 1'b1);
		m.bus_stop();
		settle(0);
		chk("stop", stp, 1'b1);
		pulse(0, 8'h00);
		pulse(2, 8'h00);
		settle(0);
		chk("cleared", {stp, ovf}, 2'h0);
		mq.delete();
		// read: preload, refill, early write dropped
		b = 8'($urandom);
		mq.push_back(b);
		pulse(1, b);
		settle(0);
		chk("tbf", tbf, 1'b1);
		m.bus_start();
		m.xfer({8'h6d, 1'b1}, q);
		settle(0);
		chk("ack_read", q[0], 1'b0);
		chk("rd_req", rrq, 1'b1);
		chk("tbf_taken", tbf, 1'b0);
		b = 8'($urandom);
		mq.push_back(b);
		pulse(1, b);
		pulse(1, ~b);
		settle(0);
		chk("ovf_tx", ovf, 1'b1);
		m.xfer({8'hff, 1'b0}, q);
		settle(0);
		chk("tx0", q[8:1], mq.pop_front());
		m.xfer({8'hff, 1'b1}, q);
		settle(0);
		chk("tx1", q[8:1], mq.pop_front());
		m.bus_stop();
		settle(0);
		chk("rd_stop", {rrq, stp}, 2'h1);
		close_out();
	end
endmodule
